// >>> include/rssm_pkg.sv
// Constants and types shared by the reset sequencer and supply monitor
package rssm_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 100;

  // Stabilisation delay lengths in CPU clock cycles
  localparam int DELAY_SHORT_CYC = 256;
  localparam int DELAY_LONG_CYC  = 4096;
  localparam int DELAY_CNT_W     = 12;
  // Counter terminal values; two cycles are eaten by the done flop and the state change
  localparam logic [DELAY_CNT_W-1:0] DELAY_LAST_SHORT = 12'(DELAY_SHORT_CYC - 2);
  localparam logic [DELAY_CNT_W-1:0] DELAY_LAST_LONG  = 12'(DELAY_LONG_CYC - 2);

  // Minimum reset pin output pulse after a watchdog underflow
  localparam int WDG_PULSE_NS = 20000;
  localparam int WDG_PULSE_CYC_INT = (WDG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] WDG_PULSE_CYC = 8'(WDG_PULSE_CYC_INT);

  // Cycles the pin input is ignored after the device stops driving it low
  localparam logic [2:0] PIN_BLANK_CYC = 3'h4;

  // Reset vector location
  localparam logic [15:0] VECTOR_ADDR_HI = 16'hfffe;
  localparam logic [15:0] VECTOR_ADDR_LO = 16'hffff;

  // Register byte offsets
  localparam logic [3:0] OFS_INTEGRITY_CTRL_STATUS = 4'h0;
  localparam logic [3:0] OFS_OPTION                = 4'h4;
  localparam logic [3:0] OFS_SEQ_STATUS            = 4'h8;

  // integrity_ctrl_status bit positions
  localparam int BIT_IRQ_ENABLE     = 6;
  localparam int BIT_WARNING_FLAG   = 5;
  localparam int BIT_LOW_SUPPLY_RF  = 4;
  localparam int BIT_WATCHDOG_RF    = 0;

  // option register bit positions
  localparam int BIT_OPT_LONG_DELAY = 0;
  localparam int BIT_OPT_LVD_EN     = 1;
  localparam int POS_OPT_THRESH     = 2;
  localparam int POS_OPT_CLK_SRC    = 4;

  // Reset values
  localparam logic       RST_IRQ_ENABLE = 1'b0;
  localparam logic [2:0] RST_CLK_SRC    = 3'h5;

  // Clock source selector codes
  localparam logic [2:0] CLK_SRC_EXTERNAL = 3'h0;
  localparam logic [2:0] CLK_SRC_RES_MIN  = 3'h1;
  localparam logic [2:0] CLK_SRC_RES_MAX  = 3'h4;
  localparam logic [2:0] CLK_SRC_RC       = 3'h5;

  // Low supply threshold codes
  localparam logic [1:0] THRESH_LOW    = 2'h0;
  localparam logic [1:0] THRESH_MEDIUM = 2'h1;
  localparam logic [1:0] THRESH_HIGH   = 2'h2;

  typedef enum logic [2:0] {
    SEQ_ACTIVE = 3'h0,
    SEQ_DELAY  = 3'h1,
    SEQ_FETCH0 = 3'h2,
    SEQ_FETCH1 = 3'h3,
    SEQ_RUN    = 3'h4
  } rssm_state_e;

endpackage

// >>> logic/rssm_delay_counter.sv
// Stabilisation delay counter with restart and short/long length select
`timescale 1ns/1ps
module rssm_delay_counter
  import rssm_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  input  wire logic restart_i,
  input  wire logic long_i,
  output logic      done_o
);

  logic [DELAY_CNT_W-1:0] count_reg;
  logic [DELAY_CNT_W-1:0] last;

  assign last = long_i ? DELAY_LAST_LONG : DELAY_LAST_SHORT;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= '0;
    end else if (restart_i || !run_i) begin
      count_reg <= '0;
    end else if (count_reg != last) begin
      count_reg <= count_reg + 12'h001;
    end
  end

  // Done only while running undisturbed; a restart drops it at the next clock edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= run_i && !restart_i && (count_reg == last);
    end
  end

endmodule

// >>> logic/rssm_reset_sequencer.sv
// Reset sequencer, supply warning monitor and clock source selection
// Summary of operation
// RULE_01 - Three reset sources: pin, low supply, watchdog
// RULE_02 - All sources act on pin; low during delay
// RULE_03 - Vector fetched from top two memory bytes
// RULE_04 - Phases: active, stabilisation delay, vector fetch
// RULE_05 - Delay 256 or 4096 cycles by option
// RULE_06 - Vector fetch takes exactly two cycles
// RULE_07 - Pin low detected asynchronously, clocks halted too
// RULE_08 - Pin is input and open-drain output
// RULE_09 - Low supply fault holds pin low
// RULE_10 - Watchdog underflow drives pin minimum pulse
// RULE_11 - Detector enable and threshold by option
// RULE_12 - Warning comparator readable live, read-only
// RULE_13 - Warning works only with detector enabled
// RULE_14 - Interrupt on every warning flag toggle
// RULE_15 - No interrupt for crossing during reset delay
// RULE_16 - Enable while low supply: interrupt at enable
// RULE_17 - Enable after recovery: single interrupt only; the code raises no interrupt at enable when the flag is clear
// RULE_18 - Clock source chosen by option setting
// RULE_19 - Resonator kept running during reset
// RULE_20 - Enable bit read-write; pending cleared on service
// RULE_21 - Low supply reset flag; software writes zero
// RULE_22 - Delay restarts if any source reasserts
// RULE_23 - Pin and comparator synchronised before use
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module rssm_reset_sequencer
  import rssm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Reset pin, open drain
  input  wire logic        rst_pin_i,
  output logic             rst_pin_o,
  output logic             rst_pin_oe_n_o,
  // Analog and peripheral sources
  input  wire logic        low_supply_i,
  input  wire logic        warning_cmp_i,
  input  wire logic        wdg_underflow_i,
  input  wire logic        warning_irq_ack_i,
  // Nonvolatile option settings
  input  wire logic        opt_long_delay_i,
  input  wire logic        opt_lvd_enable_i,
  input  wire logic [1:0]  opt_lvd_threshold_i,
  input  wire logic [2:0]  opt_clk_src_i,
  // Outputs to core and analog
  output logic             cpu_reset_o,
  output logic             vector_fetch_o,
  output logic [15:0]      vector_addr_o,
  output logic             supply_warning_irq_o,
  output logic             lvd_enable_o,
  output logic [1:0]       lvd_threshold_o,
  output logic [2:0]       clk_src_o,
  output logic             osc_keep_run_o
);

  rssm_state_e state_reg, state_next;
  logic        pin_s1_reg, pin_s2_reg, hold_s1_reg, hold_s2_reg, pin_hold_reg, pin_gate_n;
  logic        lvd_s1_reg, lvd_s2_reg, cmp_s1_reg, cmp_s2_reg, long_delay_reg, lvd_en_reg;
  logic [1:0]  thresh_reg;
  logic [2:0]  blank_reg, clk_src_reg;
  logic [7:0]  wdg_cnt_reg;
  logic        src_pin, src_lvd, src_wdg, src_any, internal_src, delay_done;
  logic        supply_warning_flag, flag_prev_reg, toggle, en_rise, irq_pending_reg;
  logic        supply_warning_irq_enable_reg, low_supply_reset_flag_reg;
  logic        watchdog_reset_flag_reg, wb_req, wb_wr, wr_ctrl;
  logic [31:0] rd_mux;

  // Synchronisers; first stages feed only the second stages
  // RULE_23 sync pin comparator
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_reg  <= 1'b1;
      pin_s2_reg  <= 1'b1;
      hold_s1_reg <= 1'b0;
      hold_s2_reg <= 1'b0;
      lvd_s1_reg  <= 1'b0;
      lvd_s2_reg  <= 1'b0;
      cmp_s1_reg  <= 1'b0;
      cmp_s2_reg  <= 1'b0;
    end else begin
      pin_s1_reg  <= rst_pin_i;
      pin_s2_reg  <= pin_s1_reg;
      hold_s1_reg <= pin_hold_reg;
      hold_s2_reg <= hold_s1_reg;
      lvd_s1_reg  <= low_supply_i;
      lvd_s2_reg  <= lvd_s1_reg;
      cmp_s1_reg  <= warning_cmp_i;
      cmp_s2_reg  <= cmp_s1_reg;
    end
  end

  // Our own drive and the pull-up rise time must not look like an external request
  assign pin_gate_n = rst_pin_i || !rst_pin_oe_n_o || (blank_reg != 3'h0);
  // RULE_07 async pin catch
  // Latch survives a halted clock; released once the synced pin is high again
  always_ff @(posedge clk_i or negedge rst_n_i or negedge pin_gate_n) begin
    if (!rst_n_i) begin
      pin_hold_reg <= 1'b0;
    end else if (!pin_gate_n) begin
      pin_hold_reg <= 1'b1;
    end else if (pin_s2_reg && hold_s2_reg) begin
      pin_hold_reg <= 1'b0;
    end
  end
  // Core reset also asserts without a clock edge
  always_ff @(posedge clk_i or negedge rst_n_i or negedge pin_gate_n) begin
    if (!rst_n_i) begin
      cpu_reset_o <= 1'b1;
    end else if (!pin_gate_n) begin
      cpu_reset_o <= 1'b1;
    end else begin
      cpu_reset_o <= (state_next == SEQ_ACTIVE) || (state_next == SEQ_DELAY);
    end
  end
  // RULE_10 watchdog pulse stretch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdg_cnt_reg <= 8'h00;
    end else if (wdg_underflow_i) begin
      wdg_cnt_reg <= WDG_PULSE_CYC;
    end else if (wdg_cnt_reg != 8'h00) begin
      wdg_cnt_reg <= wdg_cnt_reg - 8'h01;
    end
  end
  // RULE_01 merge reset sources
  assign src_pin      = hold_s2_reg;
  assign src_lvd      = lvd_en_reg && lvd_s2_reg;
  assign src_wdg      = wdg_underflow_i || (wdg_cnt_reg != 8'h00);
  assign src_any      = src_pin || src_lvd || src_wdg;
  assign internal_src = src_lvd || src_wdg;
  // RULE_04 phase sequence
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SEQ_ACTIVE: begin
        if (!src_any) begin
          state_next = SEQ_DELAY;
        end
      end
      // RULE_22 delay restart
      SEQ_DELAY: begin
        if (src_any) begin
          state_next = SEQ_ACTIVE;
        end else if (delay_done) begin
          state_next = SEQ_FETCH0;
        end
      end
      // RULE_06 two-cycle fetch
      SEQ_FETCH0: begin
        state_next = src_any ? SEQ_ACTIVE : SEQ_FETCH1;
      end
      SEQ_FETCH1: begin
        state_next = src_any ? SEQ_ACTIVE : SEQ_RUN;
      end
      SEQ_RUN: begin
        if (src_any) begin
          state_next = SEQ_ACTIVE;
        end
      end
      default: begin
        state_next = SEQ_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SEQ_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end
  // RULE_05 delay length select
  rssm_delay_counter u_delay (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .run_i     (state_reg == SEQ_DELAY),
    .restart_i (src_any),
    .long_i    (long_delay_reg),
    .done_o    (delay_done)
  );
  // RULE_03 vector address
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vector_fetch_o <= 1'b0;
      vector_addr_o  <= VECTOR_ADDR_HI;
    end else begin
      vector_fetch_o <= (state_next == SEQ_FETCH0) || (state_next == SEQ_FETCH1);
      vector_addr_o  <= (state_next == SEQ_FETCH1) ? VECTOR_ADDR_LO : VECTOR_ADDR_HI;
    end
  end
  // RULE_02 pin low in delay
  // RULE_09 low supply drives pin
  // An external-only request is not driven in the active phase, so its release stays visible
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pin_oe_n_o <= 1'b0;
    end else begin
      rst_pin_oe_n_o <= !((state_next == SEQ_DELAY) ||
                          ((state_next == SEQ_ACTIVE) && internal_src));
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blank_reg <= 3'h0;
    end else if (!rst_pin_oe_n_o) begin
      blank_reg <= PIN_BLANK_CYC;
    end else if (blank_reg != 3'h0) begin
      blank_reg <= blank_reg - 3'h1;
    end
  end
  // RULE_08 open-drain pin
  assign rst_pin_o = 1'b0;

  // RULE_11 option capture
  // RULE_18 clock source option
  // Options are only sampled while the core is held, so they are stable in run
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      long_delay_reg <= 1'b1;
      lvd_en_reg     <= 1'b0;
      thresh_reg     <= THRESH_HIGH;
      clk_src_reg    <= RST_CLK_SRC;
    end else if (state_reg == SEQ_ACTIVE) begin
      long_delay_reg <= opt_long_delay_i;
      lvd_en_reg     <= opt_lvd_enable_i;
      thresh_reg     <= opt_lvd_threshold_i;
      clk_src_reg    <= opt_clk_src_i;
    end
  end
  // RULE_19 resonator kept running
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvd_enable_o    <= 1'b0;
      lvd_threshold_o <= THRESH_HIGH;
      clk_src_o       <= RST_CLK_SRC;
      osc_keep_run_o  <= 1'b0;
    end else begin
      lvd_enable_o    <= lvd_en_reg;
      lvd_threshold_o <= thresh_reg;
      clk_src_o       <= (clk_src_reg > CLK_SRC_RC) ? CLK_SRC_RC : clk_src_reg;
      osc_keep_run_o  <= (clk_src_reg >= CLK_SRC_RES_MIN) && (clk_src_reg <= CLK_SRC_RES_MAX);
    end
  end
  // RULE_12 live warning flag
  // RULE_13 gated by detector enable
  assign supply_warning_flag = lvd_en_reg && cmp_s2_reg;
  // Wishbone decode; writes land on the edge that ack is sampled
  assign wb_req  = wb_cyc_i && wb_stb_i;
  assign wb_wr   = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign wr_ctrl = wb_wr && (wb_adr_i == OFS_INTEGRITY_CTRL_STATUS);
  assign en_rise = wr_ctrl && wb_dat_i[BIT_IRQ_ENABLE] && !supply_warning_irq_enable_reg;
  assign toggle  = supply_warning_flag != flag_prev_reg;
  // RULE_20 enable bit read-write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      supply_warning_irq_enable_reg <= RST_IRQ_ENABLE;
    end else if (wr_ctrl) begin
      supply_warning_irq_enable_reg <= wb_dat_i[BIT_IRQ_ENABLE];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_prev_reg <= 1'b0;
    end else begin
      flag_prev_reg <= supply_warning_flag;
    end
  end
  // RULE_14 toggle interrupt
  // RULE_15 none during reset
  // RULE_16 enable while low
  // RULE_17 enable after recovery
  // A new event beats the service acknowledge in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_pending_reg <= 1'b0;
    end else if ((state_reg == SEQ_RUN) &&
                 ((toggle && supply_warning_irq_enable_reg) ||
                  (en_rise && supply_warning_flag))) begin
      irq_pending_reg <= 1'b1;
    end else if (warning_irq_ack_i || !supply_warning_irq_enable_reg) begin
      irq_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      supply_warning_irq_o <= 1'b0;
    end else begin
      supply_warning_irq_o <= irq_pending_reg;
    end
  end
  // RULE_21 low supply reset flag
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_supply_reset_flag_reg <= 1'b0;
    end else if (src_lvd) begin
      low_supply_reset_flag_reg <= 1'b1;
    end else if (wr_ctrl && !wb_dat_i[BIT_LOW_SUPPLY_RF]) begin
      low_supply_reset_flag_reg <= 1'b0;
    end
  end
  // Watchdog flag is cleared by a low supply reset so it starts clean
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_reset_flag_reg <= 1'b0;
    end else if (src_lvd) begin
      watchdog_reset_flag_reg <= 1'b0;
    end else if (src_wdg) begin
      watchdog_reset_flag_reg <= 1'b1;
    end else if (wr_ctrl && !wb_dat_i[BIT_WATCHDOG_RF]) begin
      watchdog_reset_flag_reg <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_INTEGRITY_CTRL_STATUS: begin
        rd_mux[BIT_IRQ_ENABLE]    = supply_warning_irq_enable_reg;
        rd_mux[BIT_WARNING_FLAG]  = supply_warning_flag;
        rd_mux[BIT_LOW_SUPPLY_RF] = low_supply_reset_flag_reg;
        rd_mux[BIT_WATCHDOG_RF]   = watchdog_reset_flag_reg;
      end
      OFS_OPTION: begin
        rd_mux[BIT_OPT_LONG_DELAY]              = long_delay_reg;
        rd_mux[BIT_OPT_LVD_EN]                  = lvd_en_reg;
        rd_mux[POS_OPT_THRESH+1:POS_OPT_THRESH]   = thresh_reg;
        rd_mux[POS_OPT_CLK_SRC+2:POS_OPT_CLK_SRC] = clk_src_reg;
      end
      OFS_SEQ_STATUS: begin
        rd_mux[2:0] = state_reg;
        rd_mux[3]   = irq_pending_reg;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end
  // One wait state: ack the cycle after the request, drop it the cycle after
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      if (wb_req && !wb_ack_o && !wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

endmodule

// >>> sim/rssm_reset_sequencer_chk.sv
// Port-level assertions for the reset sequencer and supply monitor
`timescale 1ns/1ps
module rssm_reset_sequencer_chk
  import rssm_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        rst_pin_i,
  input wire logic        rst_pin_oe_n_o,
  input wire logic        low_supply_i,
  input wire logic        warning_cmp_i,
  input wire logic        wdg_underflow_i,
  input wire logic        warning_irq_ack_i,
  input wire logic        opt_long_delay_i,
  input wire logic        cpu_reset_o,
  input wire logic        vector_fetch_o,
  input wire logic [15:0] vector_addr_o,
  input wire logic        supply_warning_irq_o,
  input wire logic        lvd_enable_o,
  input wire logic [2:0]  clk_src_o,
  input wire logic        osc_keep_run_o
);
  // Consecutive cycles of own pin drive; saturates so long runs cannot wrap
  logic [12:0] drv_cnt_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drv_cnt_reg <= '0;
    end else if (rst_pin_oe_n_o) begin
      drv_cnt_reg <= '0;
    end else if (!drv_cnt_reg[12]) begin
      drv_cnt_reg <= drv_cnt_reg + 13'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_fetch;
    (vector_addr_o == VECTOR_ADDR_HI) ##1 (vector_fetch_o && vector_addr_o == VECTOR_ADDR_LO)
      ##1 (!vector_fetch_o && !cpu_reset_o);
  endsequence

  sequence s_quiet_ack;
    $stable(warning_cmp_i) [*4] ##0 warning_irq_ack_i;
  endsequence

  a_fetch_two_cycles: assert property ($rose(vector_fetch_o) |-> s_fetch)
    else $error("reset vector fetch out of order");
  a_delay_pin_held: assert property ($rose(vector_fetch_o) |->
    drv_cnt_reg >= (opt_long_delay_i ? 13'(DELAY_LONG_CYC) : 13'(DELAY_SHORT_CYC)))
    else $error("pin not driven for the whole delay");
  a_async_entry: assert property (!rst_pin_i |-> cpu_reset_o)
    else $error("low pin without core reset");
  a_wdg_drive: assert property (wdg_underflow_i |=> !rst_pin_oe_n_o && cpu_reset_o)
    else $error("watchdog underflow not driving pin");
  a_lvd_hold: assert property ((lvd_enable_o && low_supply_i) [*5] |->
    !rst_pin_oe_n_o && cpu_reset_o)
    else $error("low supply not holding pin low");
  a_irq_in_run: assert property ($rose(supply_warning_irq_o) |-> !$past(cpu_reset_o))
    else $error("warning interrupt raised in reset");
  a_ack_clears: assert property (s_quiet_ack |=> ##1 !supply_warning_irq_o)
    else $error("warning interrupt not cleared by service");
  a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single next-cycle pulse");
  a_osc_follows_src: assert property (osc_keep_run_o ==
    (clk_src_o >= CLK_SRC_RES_MIN && clk_src_o <= CLK_SRC_RES_MAX))
    else $error("oscillator keep-run mismatch");
endmodule

// >>> sim/rssm_board_reset.sv
// Board side of the reset pin: external pulling circuit and weak pull-up
`timescale 1ns/1ps
module rssm_board_reset (
  input  wire logic drv_i,
  input  wire logic oe_n_i,
  output logic      pin_level_o
);
  logic ext_low_reg = 1'b0;

  assign pin_level_o = ((!oe_n_i && !drv_i) || ext_low_reg) ? 1'b0 : 1'b1;

  // Called just after a rising edge; the level holds until the next call
  task automatic drive(input logic low);
    ext_low_reg <= low;
  endtask
endmodule

// >>> sim/rssm_reset_sequencer_bench.sv
// Directed bench for the reset sequencer and supply monitor
`timescale 1ns/1ps
module rssm_reset_sequencer_bench
  import rssm_pkg::*;
();
  logic        clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        rst_pin_i, rst_pin_o, rst_pin_oe_n_o, low_supply_i, warning_cmp_i;
  logic        wdg_underflow_i, warning_irq_ack_i, opt_long_delay_i, opt_lvd_enable_i;
  logic        cpu_reset_o, vector_fetch_o, supply_warning_irq_o, lvd_enable_o, osc_keep_run_o;
  logic [1:0]  opt_lvd_threshold_i, lvd_threshold_o;
  logic [2:0]  opt_clk_src_i, clk_src_o;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [15:0] vector_addr_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          err_count, num_checks, cnt;

  rssm_reset_sequencer dut (
    .clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .rst_pin_i, .rst_pin_o, .rst_pin_oe_n_o, .low_supply_i,
    .warning_cmp_i, .wdg_underflow_i, .warning_irq_ack_i, .opt_long_delay_i,
    .opt_lvd_enable_i, .opt_lvd_threshold_i, .opt_clk_src_i, .cpu_reset_o, .vector_fetch_o,
    .vector_addr_o, .supply_warning_irq_o, .lvd_enable_o, .lvd_threshold_o, .clk_src_o,
    .osc_keep_run_o
  );
  rssm_board_reset brd (.drv_i(rst_pin_o), .oe_n_i(rst_pin_oe_n_o), .pin_level_o(rst_pin_i));

  always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Classic cycle: request held until ack is sampled, then released
  task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
      n++;
      if (n > 20) begin
        err_count++;
        close_out();
      end
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    chk(rd, exp);
  endtask

  // Waits for the fetch, checks its length window and the two fetch cycles
  task automatic fetch_seq(input int lo, input int hi);
    cnt = 0;
    while (vector_fetch_o !== 1'b1) begin
      @(negedge clk_i);
      cnt++;
      if (cnt > 6000) begin
        err_count++;
        close_out();
      end
    end
    chk(32'(cnt >= lo && cnt <= hi), 32'h1);
    chk(32'({vector_addr_o, rst_pin_oe_n_o}), 32'({VECTOR_ADDR_HI, 1'b1}));
    @(negedge clk_i);
    chk(32'({vector_fetch_o, vector_addr_o}), 32'({1'b1, VECTOR_ADDR_LO}));
    @(negedge clk_i);
    chk(32'({vector_fetch_o, cpu_reset_o, rst_pin_oe_n_o}), 32'h1);
  endtask

  task automatic irq_ack();
    @(posedge clk_i);
    warning_irq_ack_i <= 1'b1;
    @(posedge clk_i);
    warning_irq_ack_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk(32'(supply_warning_irq_o), 32'h0);
  endtask

  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, low_supply_i, warning_cmp_i} = '0;
    {wdg_underflow_i, warning_irq_ack_i, opt_long_delay_i, wb_adr_i, wb_dat_i} = '0;
    opt_lvd_enable_i = 1'b1;
    opt_lvd_threshold_i = THRESH_MEDIUM;
    opt_clk_src_i = 3'h2;
    wb_sel_i = 4'h1;
    err_count = 0;
    num_checks = 0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    fetch_seq(256, 264);
    chk(32'({osc_keep_run_o, clk_src_o, lvd_enable_o, lvd_threshold_o}), 32'h55);
    rd_chk(OFS_OPTION, 32'h26);
    bus(1'b1, OFS_OPTION, 32'hff);
    rd_chk(OFS_OPTION, 32'h26);
    rd_chk(4'hc, 32'h0);
    rd_chk(OFS_SEQ_STATUS, 32'h4);
    $display("test power_up done");

    @(posedge clk_i);
    warning_cmp_i <= 1'b1;
    repeat (6) @(negedge clk_i);
    chk(32'(supply_warning_irq_o), 32'h0);
    rd_chk(OFS_INTEGRITY_CTRL_STATUS, 32'h20);
    bus(1'b1, OFS_INTEGRITY_CTRL_STATUS, 32'h40);
    repeat (3) @(negedge clk_i);
    chk(32'(supply_warning_irq_o), 32'h1);
    irq_ack();
    @(posedge clk_i);
    warning_cmp_i <= 1'b0;
    repeat (6) @(negedge clk_i);
    chk(32'(supply_warning_irq_o), 32'h1);
    irq_ack();
    bus(1'b1, 4'hc, 32'h0);
    rd_chk(OFS_INTEGRITY_CTRL_STATUS, 32'h40);
    bus(1'b1, OFS_INTEGRITY_CTRL_STATUS, 32'h0);
    bus(1'b1, OFS_INTEGRITY_CTRL_STATUS, 32'h40);
    repeat (3) @(negedge clk_i);
    chk(32'(supply_warning_irq_o), 32'h0);
    bus(1'b1, OFS_INTEGRITY_CTRL_STATUS, 32'h0);
    $display("test warning done");

    @(posedge clk_i);
    brd.drive(1'b1);
    #1;
    chk(32'({cpu_reset_o, rst_pin_i}), 32'h2);
    repeat (10) @(posedge clk_i);
    brd.drive(1'b0);
    repeat (20) @(negedge clk_i);
    chk(32'({cpu_reset_o, rst_pin_oe_n_o, rst_pin_o}), 32'h4);
    fetch_seq(225, 250);
    $display("test pin_reset done");

    @(posedge clk_i);
    low_supply_i <= 1'b1;
    repeat (40) @(negedge clk_i);
    chk(32'({cpu_reset_o, rst_pin_oe_n_o}), 32'h2);
    @(posedge clk_i);
    low_supply_i <= 1'b0;
    repeat (100) @(posedge clk_i);
    low_supply_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    low_supply_i <= 1'b0;
    fetch_seq(256, 266);
    rd_chk(OFS_INTEGRITY_CTRL_STATUS, 32'h10);
    bus(1'b1, OFS_INTEGRITY_CTRL_STATUS, 32'h0);
    rd_chk(OFS_INTEGRITY_CTRL_STATUS, 32'h0);
    $display("test low_supply done");

    opt_lvd_enable_i <= 1'b0;
    opt_lvd_threshold_i <= THRESH_HIGH;
    warning_cmp_i <= 1'b1;
    for (int c = 0; c < 6; c++) begin
      @(posedge clk_i);
      opt_clk_src_i <= 3'(c);
      opt_long_delay_i <= (c == 5);
      wdg_underflow_i <= 1'b1;
      @(posedge clk_i);
      wdg_underflow_i <= 1'b0;
      if (c == 5) begin
        fetch_seq(4290, 4306);
      end else begin
        fetch_seq(450, 466);
      end
      chk(32'({osc_keep_run_o, clk_src_o}), 32'({c >= 1 && c <= 4, 3'(c)}));
    end
    rd_chk(OFS_INTEGRITY_CTRL_STATUS, 32'h1);
    rd_chk(OFS_OPTION, 32'h59);
    chk(32'({lvd_enable_o, lvd_threshold_o}), 32'h2);
    $display("test watchdog done");
    close_out();
  end
endmodule

bind rssm_reset_sequencer rssm_reset_sequencer_chk u_chk (
  .clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rst_pin_i, .rst_pin_oe_n_o,
  .low_supply_i, .warning_cmp_i, .wdg_underflow_i, .warning_irq_ack_i, .opt_long_delay_i,
  .cpu_reset_o, .vector_fetch_o, .vector_addr_o, .supply_warning_irq_o, .lvd_enable_o,
  .clk_src_o, .osc_keep_run_o
);
